// >>> design/uvep_host.sv
/*
 * Host controller for a 4K x 8 UV-erasable memory: reads bytes and programs
 * bytes with a verify read-back. Assumes the device pins are wired directly,
 * with the supply switch raising the gate pin to the programming level while
 * vpp_en_ff is high. Requests are synchronous to clk.
 */
// Summary of operation
// - Gate may lag select without slowing access; host lags one cycle beyond access minus gate.
// - Select decodes device; gate is read strobe.
// - Programming needs high level on gate pin.
// - Program byte driven parallel on data pins.
// - One select pulse, 50 ms, under 55.
// - Every location gets its own pulse.
// - Never program with select held low.
// - Verify with gate and select low.
// - Supply rise at least 50 ns.
// - Shared select pulses program devices together.
module uvep_host #(
   parameter int PULSE_CYCLES = uvep_pkg::PULSE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rd_req,
   input wire logic wr_req,
   input wire logic [uvep_pkg::ADDR_W-1:0] req_addr,
   input wire logic [uvep_pkg::DATA_W-1:0] req_data,
   output logic busy_ff,
   output logic done_ff,
   output logic [uvep_pkg::DATA_W-1:0] rdata_ff,
   output logic verify_err_ff,
   output logic [uvep_pkg::ADDR_W-1:0] mem_addr_ff,
   output logic select_n_ff,
   output logic gate_n_ff,
   output logic vpp_en_ff,
   input wire logic [uvep_pkg::DATA_W-1:0] mem_data_i,
   output logic [uvep_pkg::DATA_W-1:0] mem_data_o_ff,
   output logic mem_data_oe_ff
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   uvep_pkg::uvep_state_t state_ff, nxt_state;
   logic [uvep_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic nxt_busy, nxt_done, nxt_verify_err, nxt_select_n, nxt_gate_n, nxt_vpp_en;
   logic nxt_data_oe;
   logic [uvep_pkg::DATA_W-1:0] nxt_rdata, nxt_data_o;
   logic [uvep_pkg::ADDR_W-1:0] nxt_addr;
   logic cnt_end;

   assign cnt_end = (cnt_ff == '0);

   // Next-state logic for the access sequencer.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_end ? cnt_ff : cnt_ff - 1'b1;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_verify_err = verify_err_ff;
      nxt_select_n = select_n_ff;
      nxt_gate_n = gate_n_ff;
      nxt_vpp_en = vpp_en_ff;
      nxt_data_oe = mem_data_oe_ff;
      nxt_rdata = rdata_ff;
      nxt_data_o = mem_data_o_ff;
      nxt_addr = mem_addr_ff;
      unique case (state_ff)
         uvep_pkg::S_IDLE:
         begin
            nxt_select_n = 1'b1;
            nxt_gate_n = 1'b1;
            if (wr_req)
            begin
               nxt_addr = req_addr;
               nxt_data_o = req_data;
               nxt_data_oe = 1'b1;
               nxt_vpp_en = 1'b1;
               nxt_busy = 1'b1;
               nxt_verify_err = 1'b0;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::RISE_CYC);
               nxt_state = uvep_pkg::S_PRISE;
            end
            else if (rd_req)
            begin
               nxt_addr = req_addr;
               nxt_select_n = 1'b0;
               nxt_busy = 1'b1;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::SEL_CYC);
               nxt_state = uvep_pkg::S_RSEL;
            end
         end
         uvep_pkg::S_RSEL:
            if (cnt_end)
            begin
               // gate lags select by SEL_CYC + 1 cycles, one more than access minus gate
               nxt_gate_n = 1'b0;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::GATE_CYC);
               nxt_state = uvep_pkg::S_RGATE;
            end
         uvep_pkg::S_RGATE:
            if (cnt_end)
            begin
               nxt_rdata = mem_data_i;
               nxt_gate_n = 1'b1;
               nxt_select_n = 1'b1;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::FLOAT_CYC);
               nxt_state = uvep_pkg::S_RFLOAT;
            end
         uvep_pkg::S_RFLOAT:
            // wait for the outputs to float
            if (cnt_end)
            begin
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
               nxt_state = uvep_pkg::S_IDLE;
            end
         uvep_pkg::S_PRISE:
            if (cnt_end)
            begin
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::SETUP_CYC);
               nxt_state = uvep_pkg::S_PSETUP;
            end
         uvep_pkg::S_PSETUP:
            if (cnt_end)
            begin
               nxt_select_n = 1'b0;
               nxt_cnt = PULSE_CYCLES[uvep_pkg::CNT_W-1:0];
               nxt_state = uvep_pkg::S_PPULSE;
            end
         uvep_pkg::S_PPULSE:
            if (cnt_end)
            begin
               nxt_select_n = 1'b1;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::HOLD_CYC);
               nxt_state = uvep_pkg::S_PHOLD;
            end
         uvep_pkg::S_PHOLD:
            if (cnt_end)
            begin
               nxt_data_oe = 1'b0;
               nxt_vpp_en = 1'b0;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::RECOVER_CYC);
               nxt_state = uvep_pkg::S_VREC;
            end
         uvep_pkg::S_VREC:
            if (cnt_end)
            begin
               // verify with gate and select low
               nxt_select_n = 1'b0;
               nxt_gate_n = 1'b0;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::VERIFY_CYC);
               nxt_state = uvep_pkg::S_VREAD;
            end
         uvep_pkg::S_VREAD:
            if (cnt_end)
            begin
               // only zeros can be written; mismatch flags error
               nxt_rdata = mem_data_i;
               nxt_verify_err = (mem_data_i != mem_data_o_ff);
               nxt_select_n = 1'b1;
               nxt_gate_n = 1'b1;
               nxt_cnt = uvep_pkg::CNT_W'(uvep_pkg::FLOAT_CYC);
               nxt_state = uvep_pkg::S_VFLOAT;
            end
         uvep_pkg::S_VFLOAT:
            // allow float delay before next use
            if (cnt_end)
            begin
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
               nxt_state = uvep_pkg::S_IDLE;
            end
      endcase
   end

   // Registers for the sequencer and all pin drivers.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= uvep_pkg::S_IDLE;
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         verify_err_ff <= 1'b0;
         select_n_ff <= 1'b1;
         gate_n_ff <= 1'b1;
         vpp_en_ff <= 1'b0;
         mem_data_oe_ff <= 1'b0;
         rdata_ff <= uvep_pkg::ERASED_BYTE;
         mem_data_o_ff <= '0;
         mem_addr_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         verify_err_ff <= nxt_verify_err;
         select_n_ff <= nxt_select_n;
         gate_n_ff <= nxt_gate_n;
         vpp_en_ff <= nxt_vpp_en;
         mem_data_oe_ff <= nxt_data_oe;
         rdata_ff <= nxt_rdata;
         mem_data_o_ff <= nxt_data_o;
         mem_addr_ff <= nxt_addr;
      end
   end
endmodule

// >>> design/uvep_pkg.sv
/*
 * Package for the controller that drives a 4K x 8 UV-erasable memory port.
 * Assumes a 10 MHz system clock; all times are converted to cycle counts here.
 */
package uvep_pkg;
   // ------------------------------------------------------------------
   // Clock and sizes
   // ------------------------------------------------------------------
   localparam int CLK_MHZ = 10;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
   // ------------------------------------------------------------------
   // Times in their own units
   // ------------------------------------------------------------------
   localparam int ACCESS_NS = 450;        // Address access time, slowest grade.
   localparam int GATE_NS = 150;          // Gate to output delay, slowest grade.
   localparam int FLOAT_NS = 130;         // Output float delay.
   localparam int SETUP_US = 2;           // Address, data and supply setup.
   localparam int HOLD_US = 2;            // Data hold after the pulse.
   localparam int RECOVER_US = 2;         // Supply recovery before verify.
   localparam int VERIFY_US = 1;          // Data valid from select in verify.
   localparam int PULSE_MS = 50;          // Nominal program pulse.
   localparam int PULSE_MAX_MS = 55;      // Longest program pulse.
   localparam int RISE_NS = 50;           // Least supply rise time.
   // ------------------------------------------------------------------
   // Cycle counts: least times round up, no count below one
   // ------------------------------------------------------------------
   localparam int CNT_W = 20;
   localparam int SEL_CYC = (ACCESS_NS - GATE_NS) * CLK_MHZ / 1000;
   localparam int GATE_CYC = (GATE_NS * CLK_MHZ + 999) / 1000 + 1;
   localparam int FLOAT_CYC = (FLOAT_NS * CLK_MHZ + 999) / 1000 + 1;
   localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
   localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
   localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
   localparam int VERIFY_CYC = VERIFY_US * CLK_MHZ + 1;
   localparam int RISE_CYC = (RISE_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
   localparam int PULSE_MAX_CYC = PULSE_MAX_MS * 1000 * CLK_MHZ;
   // ------------------------------------------------------------------
   // Controller states
   // ------------------------------------------------------------------
   typedef enum logic [10:0] {
      S_IDLE   = 11'h001,
      S_RSEL   = 11'h002,
      S_RGATE  = 11'h004,
      S_RFLOAT = 11'h008,
      S_PRISE  = 11'h010,
      S_PSETUP = 11'h020,
      S_PPULSE = 11'h040,
      S_PHOLD  = 11'h080,
      S_VREC   = 11'h100,
      S_VREAD  = 11'h200,
      S_VFLOAT = 11'h400
   } uvep_state_t;
endpackage

// >>> sim/uvep_host_assertions.sv
/*
 * Pin timing checks for the memory port host.
 * Assumes it is bound to uvep_host and shares its pulse length.
 */
module uvep_host_assertions #(
   parameter int PULSE_CYCLES = uvep_pkg::PULSE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic busy_ff,
   input wire logic done_ff,
   input wire logic select_n_ff,
   input wire logic gate_n_ff,
   input wire logic vpp_en_ff,
   input wire logic mem_data_oe_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Counts the cycles for which select has been low; a long pulse needs no deep history.
   logic [31:0] low_cnt_ff;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         low_cnt_ff <= 32'h0;
      else if (select_n_ff)
         low_cnt_ff <= 32'h0;
      else
         low_cnt_ff <= low_cnt_ff + 32'h1;
   end
   property p_pulse;
      $rose(select_n_ff) && vpp_en_ff |-> low_cnt_ff == 32'(PULSE_CYCLES + 1);
   endproperty
   a_pulse: assert property (p_pulse) else $error("program pulse length wrong");
   property p_gate;
      !gate_n_ff |-> !select_n_ff && !vpp_en_ff;
   endproperty
   a_gate: assert property (p_gate) else $error("gate low without select");
   property p_lag;
      $fell(select_n_ff) && gate_n_ff && !vpp_en_ff |-> gate_n_ff [*4] ##1 !gate_n_ff;
   endproperty
   a_lag: assert property (p_lag) else $error("gate lag after select wrong");
   property p_drive;
      mem_data_oe_ff |-> vpp_en_ff && gate_n_ff;
   endproperty
   a_drive: assert property (p_drive) else $error("data driven outside programming");
   property p_setup;
      $fell(select_n_ff) && vpp_en_ff |-> $past(vpp_en_ff, 20) && $past(mem_data_oe_ff, 20);
   endproperty
   a_setup: assert property (p_setup) else $error("pulse before setup time");
   property p_hold;
      $rose(select_n_ff) && vpp_en_ff |-> (vpp_en_ff && mem_data_oe_ff) [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("data not held after pulse");
   property p_float;
      $rose(done_ff) |-> $past(select_n_ff, 3) && $past(gate_n_ff, 3) && !vpp_en_ff;
   endproperty
   a_float: assert property (p_float) else $error("done before float time");
   property p_rtime;
      $rose(busy_ff) && !vpp_en_ff |-> ##12 done_ff;
   endproperty
   a_rtime: assert property (p_rtime) else $error("read took wrong time");
   c_read: cover property ($rose(busy_ff) && !vpp_en_ff);
   c_prog: cover property ($rose(select_n_ff) && vpp_en_ff);
   c_verify: cover property (!gate_n_ff && !select_n_ff && $past(vpp_en_ff, 30));
endmodule
bind uvep_host uvep_host_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) uvep_host_assertions_inst (
   .clk, .rst, .busy_ff, .done_ff, .select_n_ff, .gate_n_ff, .vpp_en_ff, .mem_data_oe_ff);

// >>> sim/uvep_host_tb.sv
/*
 * Self-checking bench for the memory port host with a device model.
 * Assumes a short program pulse so that the run stays brief.
 */
module uvep_host_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd_req = 1'b0;
   logic wr_req = 1'b0;
   logic [11:0] req_addr = 12'h000;
   logic [7:0] req_data = 8'h00;
   logic busy_ff, done_ff, verify_err_ff, select_n_ff, gate_n_ff, vpp_en_ff, oe;
   logic [7:0] rdata_ff, data_o, dq, bus;
   logic [11:0] mem_addr_ff;
   int n_mismatch = 0;
   int compares = 0;
   // Resolves the shared data pins and makes the clock.
   assign bus = oe ? data_o : dq;
   always #50 clk = ~clk;
   uvep_host #(.PULSE_CYCLES(50)) uvep_host_inst (.clk, .rst, .rd_req, .wr_req, .req_addr,
      .req_data, .busy_ff, .done_ff, .rdata_ff, .verify_err_ff, .mem_addr_ff, .select_n_ff,
      .gate_n_ff, .vpp_en_ff, .mem_data_i(bus), .mem_data_o_ff(data_o), .mem_data_oe_ff(oe));
   uvep_mem_model uvep_mem_model_inst (.addr(mem_addr_ff), .select_n(select_n_ff),
      .gate_n(gate_n_ff), .vpp_en(vpp_en_ff), .bus_i(bus), .dq(dq));
   task automatic complete_run;
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Issues one request, optionally pokes a write while busy, waits for done.
   task automatic run_op(input logic rd, input logic wr, input logic [11:0] a,
      input logic [7:0] d, input logic poke);
      int n;
      @(posedge clk);
      #1;
      {rd_req, wr_req, req_addr, req_data} = {rd, wr, a, d};
      @(posedge clk);
      #1;
      {rd_req, wr_req, req_addr, req_data} = {1'b0, poke, 12'h7ff, 8'h00};
      @(posedge clk);
      #1;
      wr_req = 1'b0;
      for (n = 0; n < 2000 && done_ff !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
      end
      check({6'h0, busy_ff, done_ff}, 8'h01);
   endtask
   task automatic t_erased;
      run_op(1'b1, 1'b0, 12'hfff, 8'h00, 1'b0);
      check(rdata_ff, 8'hff);
   endtask
   // Programs one byte, then reads it back; the error flag is checked on its own.
   task automatic t_program;
      run_op(1'b1, 1'b1, 12'h123, 8'h5a, 1'b0);
      check(rdata_ff, 8'h5a);
      check({7'h00, verify_err_ff}, 8'h00);
      run_op(1'b1, 1'b0, 12'h123, 8'h00, 1'b0);
      check(rdata_ff, 8'h5a);
   endtask
   // Ones cannot be written back, so the verify must flag the byte.
   task automatic t_ones_kept;
      run_op(1'b0, 1'b1, 12'h123, 8'hff, 1'b0);
      check(rdata_ff, 8'h5a);
      check({7'h00, verify_err_ff}, 8'h01);
      run_op(1'b0, 1'b1, 12'h000, 8'h00, 1'b0);
      check(rdata_ff, 8'h00);
      check({7'h00, verify_err_ff}, 8'h00);
   endtask
   task automatic t_refused;
      run_op(1'b1, 1'b0, 12'h123, 8'h00, 1'b1);
      check(rdata_ff, 8'h5a);
      run_op(1'b1, 1'b0, 12'h7ff, 8'h00, 1'b0);
      check(rdata_ff, 8'hff);
   endtask
   task automatic t_reset_mid;
      @(posedge clk);
      #1;
      {wr_req, req_addr, req_data} = {1'b1, 12'h456, 8'h00};
      repeat (10) @(posedge clk);
      #1;
      {rst, wr_req} = 2'b10;
      #1;
      check({6'h0, select_n_ff, vpp_en_ff}, 8'h02);
      @(posedge clk);
      #1;
      rst = 1'b0;
      run_op(1'b1, 1'b0, 12'h456, 8'h00, 1'b0);
      check(rdata_ff, 8'hff);
   endtask
   // Main sequence after a four-cycle reset.
   initial
   begin
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      t_erased();
      t_program();
      t_ones_kept();
      t_refused();
      t_reset_mid();
      complete_run();
   end
   // Cuts a hang short well beyond the expected run time.
   initial
   begin
      #500000;
      n_mismatch++;
      complete_run();
   end
endmodule

// >>> sim/uvep_mem_model.sv
/*
 * Behavioural model of the 4K x 8 memory on the far side of the host.
 * Assumes bus_i carries the resolved level of the shared data pins.
 */
module uvep_mem_model (
   input wire logic [11:0] addr,
   input wire logic select_n,
   input wire logic gate_n,
   input wire logic vpp_en,
   input wire logic [7:0] bus_i,
   output logic [7:0] dq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cells [0:4095];
   logic drv;
   initial
   begin
      foreach (cells[i])
         cells[i] = 8'hff;
      dq = 8'h00;
   end
   // Pins are driven only when selected and gated at a normal level.
   assign drv = !select_n && !gate_n && !vpp_en;
   // Data after the gate delay; released pins show the inverse of the last value.
   always @(drv or addr)
   begin
      if (drv)
         dq <= #(uvep_pkg::GATE_NS) cells[addr];
      else
         dq <= #(uvep_pkg::FLOAT_NS) ~dq;
   end
   // Bits are cleared only at the end of a select pulse under the high level.
   always @(posedge select_n)
   begin
      if (vpp_en)
         cells[addr] = cells[addr] & bus_i;
   end
endmodule
